// ### src/sqv_ctrl_regs.sv
// Queue split, link change interrupt and VLAN insert control register bank
`timescale 1ns/1ps
`default_nettype none
module sqv_ctrl_regs
#(
   parameter longint unsigned PAUSE_CYCLES = sqv_pkg::PAUSE_CYC
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   output logic      [7:0]  o_rdata,
   output logic             o_rvld,
   input  wire logic        i_p1_link,
   input  wire logic        i_p2_link,
   input  wire logic        i_p3_link,
   input  wire logic        i_prio_cfg,
   input  wire logic        i_two_queue,
   input  wire logic [3:0]  i_p2_nonempty,
   input  wire logic [3:0]  i_p3_nonempty,
   input  wire logic        i_p2_take,
   input  wire logic        i_p3_take,
   input  wire logic        i_pause_req,
   output logic      [1:0]  o_p2_grant,
   output logic             o_p2_grant_vld,
   output logic      [1:0]  o_p3_grant,
   output logic             o_p3_grant_vld,
   output logic             o_flow_ctrl_invalid,
   output logic             o_link_irq_n,
   output logic      [1:0]  o_fiber_thr_hi,
   output logic             o_reg18_disable,
   output logic      [5:0]  o_vid_insert
);
   logic [7:0]  split_r [0:7];
   logic [7:0]  interrupt_enable_r;
   logic [7:0]  link_change_status_r;
   logic [7:0]  pause_off_limit_enable_r;
   logic [7:0]  fiber_threshold_select_r;
   logic [7:0]  regulator_control_r;
   logic [7:0]  source_vid_insert_r;
   logic [2:0]  p1_s_r;
   logic [2:0]  p2_s_r;
   logic [2:0]  p3_s_r;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;
   logic [31:0] pause_cnt_r;
   logic [3:0]  p2_sel;
   logic [3:0]  p3_sel;
   logic [7:0]  rdata_nxt;
   logic        prio_s1_r;
   logic        prio_s2_r;

   // Link levels come from the PHYs, so two stages before the edge detect
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         p1_s_r    <= 3'h0;
         p2_s_r    <= 3'h0;
         p3_s_r    <= 3'h0;
         prio_s1_r <= 1'b0;
         prio_s2_r <= 1'b0;
      end
      else
      begin
         p1_s_r    <= {p1_s_r[1:0], i_p1_link};
         p2_s_r    <= {p2_s_r[1:0], i_p2_link};
         p3_s_r    <= {p3_s_r[1:0], i_p3_link};
         prio_s1_r <= i_prio_cfg;
         prio_s2_r <= prio_s1_r;
      end
   end

   always_comb
   begin
      flag_set = 8'h00;
      flag_set[sqv_pkg::LINK_P12_BIT] = (p1_s_r[2] ^ p1_s_r[1])
                                        | (p2_s_r[2] ^ p2_s_r[1]);
      flag_set[sqv_pkg::LINK_P3_BIT]  = p3_s_r[2] ^ p3_s_r[1];
      flag_set[sqv_pkg::LINK_P2_BIT]  = p2_s_r[2] ^ p2_s_r[1];
      flag_set[sqv_pkg::LINK_P1_BIT]  = p1_s_r[2] ^ p1_s_r[1];
      flag_clr = (i_wr && i_addr == sqv_pkg::ADDR_LINK_STAT) ? i_wdata : 8'h00;
   end

   // Set beats a same-cycle clear, so no link event is lost
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         link_change_status_r <= 8'h00;
      else
         link_change_status_r <= ((link_change_status_r & ~flag_clr) | flag_set)
                                 & sqv_pkg::LINK_MASK;
   end

   // Split groups; reserved low bits hold their weights and ignore writes
   generate
      for (genvar g = 0; g < 8; g++)
      begin : g_split
         localparam logic [7:0] ADDR = sqv_pkg::ADDR_P2_Q3 + 8'(g);
         localparam logic [6:0] RSV  = (g % 4 == 0) ? sqv_pkg::SPLIT_Q3_RST :
                                       (g % 4 == 1) ? sqv_pkg::SPLIT_Q2_RST :
                                       (g % 4 == 2) ? sqv_pkg::SPLIT_Q1_RST :
                                                      sqv_pkg::SPLIT_Q0_RST;
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               split_r[g] <= {1'b1, RSV};
            else if (i_wr && i_addr == ADDR)
               split_r[g] <= {i_wdata[sqv_pkg::SEL_BIT], RSV};
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         interrupt_enable_r       <= sqv_pkg::IRQ_EN_RST;
         pause_off_limit_enable_r <= 8'h00;
         fiber_threshold_select_r <= 8'h00;
         regulator_control_r      <= 8'h00;
         source_vid_insert_r      <= 8'h00;
      end
      else if (i_wr)
      begin
         unique case (i_addr)
            sqv_pkg::ADDR_IRQ_EN: interrupt_enable_r       <= i_wdata;
            sqv_pkg::ADDR_PAUSE:  pause_off_limit_enable_r <= i_wdata;
            sqv_pkg::ADDR_FIBER:  fiber_threshold_select_r <= i_wdata & sqv_pkg::FIBER_MASK;
            sqv_pkg::ADDR_REG18:  regulator_control_r      <= i_wdata & sqv_pkg::REG18_MASK;
            sqv_pkg::ADDR_VID:    source_vid_insert_r      <= i_wdata & sqv_pkg::VID_MASK;
            default:              ;
         endcase
      end
   end

   always_comb
   begin
      unique case (i_addr)
         sqv_pkg::ADDR_P2_Q3:   rdata_nxt = split_r[0];
         sqv_pkg::ADDR_P2_Q2:   rdata_nxt = split_r[1];
         sqv_pkg::ADDR_P2_Q1:   rdata_nxt = split_r[2];
         sqv_pkg::ADDR_P2_Q0:   rdata_nxt = split_r[3];
         sqv_pkg::ADDR_P3_Q3:   rdata_nxt = split_r[4];
         sqv_pkg::ADDR_P3_Q2:   rdata_nxt = split_r[5];
         sqv_pkg::ADDR_P3_Q1:   rdata_nxt = split_r[6];
         sqv_pkg::ADDR_P3_Q0:   rdata_nxt = split_r[7];
         sqv_pkg::ADDR_IRQ_EN:    rdata_nxt = interrupt_enable_r;
         sqv_pkg::ADDR_LINK_STAT: rdata_nxt = link_change_status_r;
         sqv_pkg::ADDR_PAUSE:     rdata_nxt = pause_off_limit_enable_r;
         sqv_pkg::ADDR_FIBER:     rdata_nxt = fiber_threshold_select_r;
         sqv_pkg::ADDR_REG18:     rdata_nxt = regulator_control_r;
         sqv_pkg::ADDR_VID:       rdata_nxt = source_vid_insert_r;
         default:               rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 8'h00;
         o_rvld  <= 1'b0;
      end
      else
      begin
         o_rvld  <= i_rd;
         o_rdata <= i_rd ? rdata_nxt : 8'h00;
      end
   end

   // Enable register is written before the clear; only gating lives here
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_link_irq_n <= 1'b1;
      else
         o_link_irq_n <= ~|(link_change_status_r & interrupt_enable_r);
   end

   // Pause held continuously for the limit time forces flow control off
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pause_cnt_r         <= 32'h0;
         o_flow_ctrl_invalid <= 1'b0;
      end
      else if (pause_off_limit_enable_r[0] && i_pause_req)
      begin
         if (64'(pause_cnt_r) + 64'h1 >= PAUSE_CYCLES)
            o_flow_ctrl_invalid <= 1'b1;
         else
            pause_cnt_r <= pause_cnt_r + 32'h1;
      end
      else
      begin
         pause_cnt_r         <= 32'h0;
         o_flow_ctrl_invalid <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_fiber_thr_hi  <= 2'b00;
         o_reg18_disable <= 1'b0;
         o_vid_insert    <= 6'h00;
      end
      else
      begin
         o_fiber_thr_hi  <= {fiber_threshold_select_r[sqv_pkg::FIB_P2_BIT],
                             fiber_threshold_select_r[sqv_pkg::FIB_P1_BIT]};
         o_reg18_disable <= regulator_control_r[sqv_pkg::REG18_BIT];
         o_vid_insert    <= source_vid_insert_r[5:0];
      end
   end

   always_comb
   begin
      for (int q = 0; q < 4; q++)
      begin
         p2_sel[q] = split_r[q][sqv_pkg::SEL_BIT];
         p3_sel[q] = split_r[q + 4][sqv_pkg::SEL_BIT];
      end
   end

   // Independent scheduler per egress port
   sqv_queue_sched u_p2_sched
   (
      .i_sys_clk   (i_sys_clk),
      .i_resetn    (i_resetn),
      .i_sel       (p2_sel),
      .i_prio_cfg  (prio_s2_r),
      .i_two_queue (i_two_queue),
      .i_nonempty  (i_p2_nonempty),
      .i_take      (i_p2_take),
      .o_grant     (o_p2_grant),
      .o_grant_vld (o_p2_grant_vld),
      .o_mode      ()
   );

   sqv_queue_sched u_p3_sched
   (
      .i_sys_clk   (i_sys_clk),
      .i_resetn    (i_resetn),
      .i_sel       (p3_sel),
      .i_prio_cfg  (prio_s2_r),
      .i_two_queue (i_two_queue),
      .i_nonempty  (i_p3_nonempty),
      .i_take      (i_p3_take),
      .o_grant     (o_p3_grant),
      .o_grant_vld (o_p3_grant_vld),
      .o_mode      ()
   );
endmodule : sqv_ctrl_regs
`default_nettype wire

// ### inc/sqv_pkg.sv
// Register map, field layout and timing constants for the queue, link-irq and VLAN control bank
`default_nettype none
package sqv_pkg;
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 8;
   localparam logic [7:0] ADDR_P2_Q3   = 8'hb3;
   localparam logic [7:0] ADDR_P2_Q2   = 8'hb4;
   localparam logic [7:0] ADDR_P2_Q1   = 8'hb5;
   localparam logic [7:0] ADDR_P2_Q0   = 8'hb6;
   localparam logic [7:0] ADDR_P3_Q3   = 8'hb7;
   localparam logic [7:0] ADDR_P3_Q2   = 8'hb8;
   localparam logic [7:0] ADDR_P3_Q1   = 8'hb9;
   localparam logic [7:0] ADDR_P3_Q0   = 8'hba;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'hbb;
   localparam logic [7:0] ADDR_LINK_STAT = 8'hbc;
   localparam logic [7:0] ADDR_PAUSE   = 8'hbd;
   localparam logic [7:0] ADDR_FIBER   = 8'hc0;
   localparam logic [7:0] ADDR_REG18   = 8'hc1;
   localparam logic [7:0] ADDR_VID     = 8'hc2;
   localparam int unsigned SEL_BIT     = 7;
   localparam logic [6:0] SPLIT_Q3_RST = 7'h08;
   localparam logic [6:0] SPLIT_Q2_RST = 7'h04;
   localparam logic [6:0] SPLIT_Q1_RST = 7'h02;
   localparam logic [6:0] SPLIT_Q0_RST = 7'h01;
   localparam logic [7:0] IRQ_EN_RST   = 8'h00;
   localparam int unsigned LINK_P12_BIT = 7;
   localparam int unsigned LINK_P3_BIT  = 2;
   localparam int unsigned LINK_P2_BIT  = 1;
   localparam int unsigned LINK_P1_BIT  = 0;
   localparam logic [7:0] LINK_MASK     = 8'h87;
   localparam logic [7:0] FIBER_MASK   = 8'hc0;
   localparam int unsigned FIB_P2_BIT  = 7;
   localparam int unsigned FIB_P1_BIT  = 6;
   localparam logic [7:0] REG18_MASK   = 8'h40;
   localparam int unsigned REG18_BIT   = 6;
   localparam logic [7:0] VID_MASK     = 8'h3f;
   localparam int unsigned PRIO_CFG_BIT = 3;
   localparam int unsigned NQ          = 4;
   localparam int unsigned CLK_HZ      = 40000000;
   localparam int unsigned PAUSE_MS    = 160;
   localparam longint unsigned PAUSE_CYC = longint'(CLK_HZ) * PAUSE_MS / 1000;
   localparam logic [3:0] WEIGHT_Q3    = 4'h8;
   localparam logic [3:0] WEIGHT_Q2    = 4'h4;
   localparam logic [3:0] WEIGHT_Q1    = 4'h2;
   localparam logic [3:0] WEIGHT_Q0    = 4'h1;
   typedef enum logic [2:0]
   {
      SQV_SCHED_STRICT   = 3'h1,
      SQV_SCHED_WEIGHTED = 3'h2,
      SQV_SCHED_MIXED    = 3'h4
   } sqv_sched_t;
endpackage : sqv_pkg
`default_nettype wire

// ### src/sqv_queue_sched.sv
// Per-port egress queue picker: strict priority or 8:4:2:1 / 2:1 weighted
`timescale 1ns/1ps
`default_nettype none
module sqv_queue_sched
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic [3:0]  i_sel,
   input  wire logic        i_prio_cfg,
   input  wire logic        i_two_queue,
   input  wire logic [3:0]  i_nonempty,
   input  wire logic        i_take,
   output logic      [1:0]  o_grant,
   output logic             o_grant_vld,
   output logic      [2:0]  o_mode
);
   sqv_pkg::sqv_sched_t mode_nxt;
   logic [3:0]          credit_r [0:3];
   logic [1:0]          strict_q;
   logic                strict_vld;
   logic [1:0]          wq;
   logic                wvld;
   logic [3:0]          elig;
   logic [3:0]          wt [0:3];

   assign wt[3] = sqv_pkg::WEIGHT_Q3;
   assign wt[2] = sqv_pkg::WEIGHT_Q2;
   assign wt[1] = i_two_queue ? sqv_pkg::WEIGHT_Q1 : sqv_pkg::WEIGHT_Q1;
   assign wt[0] = i_two_queue ? sqv_pkg::WEIGHT_Q0 : sqv_pkg::WEIGHT_Q0;

   always_comb
   begin
      if (&i_sel)
         mode_nxt = sqv_pkg::SQV_SCHED_WEIGHTED;
      else if (~|i_sel && !i_prio_cfg)
         mode_nxt = sqv_pkg::SQV_SCHED_STRICT;
      else
         mode_nxt = sqv_pkg::SQV_SCHED_MIXED;
   end

   // Highest nonempty queue first
   always_comb
   begin
      strict_vld = |i_nonempty;
      if (i_nonempty[3])
         strict_q = 2'd3;
      else if (i_nonempty[2])
         strict_q = 2'd2;
      else if (i_nonempty[1])
         strict_q = 2'd1;
      else
         strict_q = 2'd0;
   end

   // In two-queue use only Q1/Q0 carry traffic, giving 2:1
   always_comb
   begin
      elig = '0;
      for (int q = 0; q < 4; q++)
      begin
         elig[q] = i_nonempty[q] && (credit_r[q] != 4'h0);
      end
      wvld = |i_nonempty;
      if (elig[3])
         wq = 2'd3;
      else if (elig[2])
         wq = 2'd2;
      else if (elig[1])
         wq = 2'd1;
      else if (elig[0])
         wq = 2'd0;
      else
         wq = strict_q;
   end

   // Credits reload when no eligible queue remains, so the ratio holds per round
   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_credit
         always_ff @(posedge i_sys_clk or negedge i_resetn)
         begin
            if (!i_resetn)
               credit_r[g] <= 4'h0;
            else if (i_take && o_grant_vld && mode_nxt == sqv_pkg::SQV_SCHED_WEIGHTED)
            begin
               if (elig == '0)
                  credit_r[g] <= (wq == 2'(g)) ? wt[g] - 4'h1 : wt[g];
               else if (wq == 2'(g))
                  credit_r[g] <= credit_r[g] - 4'h1;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_grant     <= 2'd0;
         o_grant_vld <= 1'b0;
         o_mode      <= sqv_pkg::SQV_SCHED_WEIGHTED;
      end
      else
      begin
         o_mode      <= mode_nxt;
         o_grant_vld <= (mode_nxt == sqv_pkg::SQV_SCHED_WEIGHTED) ? wvld : strict_vld;
         o_grant     <= (mode_nxt == sqv_pkg::SQV_SCHED_WEIGHTED) ? wq : strict_q;
      end
   end
endmodule : sqv_queue_sched
`default_nettype wire

// ### dv/sqv_ctrl_regs_monitor.sv
// Assertion checker for the control register bank ports
`timescale 1ns/1ps
`default_nettype none
module sqv_ctrl_regs_monitor
(
   input wire logic       i_sys_clk,
   input wire logic       i_resetn,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic       o_rvld,
   input wire logic       i_p2_link,
   input wire logic       o_link_irq_n,
   input wire logic [1:0] o_fiber_thr_hi,
   input wire logic       o_reg18_disable,
   input wire logic [5:0] o_vid_insert
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   logic [7:0] en_m;
   // Enable shadow, so the link property knows the mask
   always_ff @(posedge i_sys_clk or negedge i_resetn)
      if (!i_resetn)
         en_m <= 8'h00;
      else if (i_wr && i_addr == 8'hbb)
         en_m <= i_wdata;
   sequence s_mask_all;
      i_wr && i_addr == 8'hbb && i_wdata == 8'h00 ##1 !(i_wr && i_addr == 8'hbb);
   endsequence
   // Writes to enable or status within the wait would spoil the outcome
   sequence s_p2_event;
      $changed(i_p2_link) && en_m[1]
         ##1 (en_m[1] && !(i_wr && (i_addr == 8'hbb || i_addr == 8'hbc)))[*3];
   endsequence
   property p_vid;
      logic [7:0] d;
      (i_wr && i_addr == 8'hc2, d = i_wdata) |-> ##2 o_vid_insert == d[5:0];
   endproperty
   property p_fib;
      logic [7:0] d;
      (i_wr && i_addr == 8'hc0, d = i_wdata) |-> ##2 o_fiber_thr_hi == d[7:6];
   endproperty
   property p_ldo;
      logic [7:0] d;
      (i_wr && i_addr == 8'hc1, d = i_wdata) |-> ##2 o_reg18_disable == d[6];
   endproperty
   property p_split;
      logic [7:0] a;
      (i_rd && i_addr >= 8'hb3 && i_addr <= 8'hba, a = i_addr - 8'hb3)
         |=> o_rvld && o_rdata[6:0] == (7'h08 >> a[1:0]);
   endproperty
   property p_stat_rsv;
      i_rd && i_addr == 8'hbc |=> o_rvld && o_rdata[6:3] == 4'h0;
   endproperty
   property p_unmapped;
      i_rd && i_addr == 8'hbe |=> o_rvld && o_rdata == 8'h00;
   endproperty
   property p_rvld;
      !i_rd |=> !o_rvld;
   endproperty
   property p_mask;
      s_mask_all |=> o_link_irq_n;
   endproperty
   property p_link;
      s_p2_event |=> !o_link_irq_n;
   endproperty
   a_vid: assert property (p_vid) else $error("vid insert mismatch");
   a_fib: assert property (p_fib) else $error("fiber threshold mismatch");
   a_ldo: assert property (p_ldo) else $error("regulator disable mismatch");
   a_split: assert property (p_split) else $error("split low bits wrong");
   a_stat_rsv: assert property (p_stat_rsv) else $error("status bits 6..3 set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   a_rvld: assert property (p_rvld) else $error("read valid without read");
   a_mask: assert property (p_mask) else $error("masked irq asserted");
   a_link: assert property (p_link) else $error("irq missing on link change");
endmodule : sqv_ctrl_regs_monitor
bind sqv_ctrl_regs sqv_ctrl_regs_monitor u_mon
(
   .i_sys_clk, .i_resetn, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvld,
   .i_p2_link, .o_link_irq_n, .o_fiber_thr_hi, .o_reg18_disable, .o_vid_insert
);
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        i_sys_clk = 1'b0;
   logic        i_resetn  = 1'b0;
   logic        i_wr = 1'b0, i_rd = 1'b0, p1 = 1'b0, p2 = 1'b0, p3 = 1'b0;
   logic        tk2 = 1'b0, tk3 = 1'b0, pause = 1'b0;
   logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00;
   logic [3:0]  ne2 = 4'h0, ne3 = 4'h0;
   logic [7:0]  rdata;
   logic        rvld, gv2, gv3, finv, irq_n, ldo;
   logic [1:0]  g2, g3, fib;
   logic [5:0]  vid;
   logic [31:0] seed = 32'h0000c741;
   logic [7:0]  exp_q [$];
   int          n_fail = 0, samples_checked = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   sqv_ctrl_regs #(.PAUSE_CYCLES(20)) dut
   (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rdata), .o_rvld(rvld),
      .i_p1_link(p1), .i_p2_link(p2), .i_p3_link(p3), .i_prio_cfg(1'b0),
      .i_two_queue(1'b0), .i_p2_nonempty(ne2), .i_p3_nonempty(ne3),
      .i_p2_take(tk2), .i_p3_take(tk3), .i_pause_req(pause),
      .o_p2_grant(g2), .o_p2_grant_vld(gv2), .o_p3_grant(g3), .o_p3_grant_vld(gv3),
      .o_flow_ctrl_invalid(finv), .o_link_irq_n(irq_n), .o_fiber_thr_hi(fib),
      .o_reg18_disable(ldo), .o_vid_insert(vid)
   );
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp_v);
      samples_checked++;
      if (got !== exp_v)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp_v);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
   endtask : rd
   // Synchroniser adds latency, so allow a generous settle
   task automatic lnk(input int p, input logic [7:0] e);
      @(posedge i_sys_clk);
      case (p)
         1: p1 <= ~p1;
         2: p2 <= ~p2;
         default: p3 <= ~p3;
      endcase
      cyc(6);
      rd(8'hbc, e);
   endtask : lnk
   // Read data sampled mid-cycle, clear of edge races
   always @(negedge i_sys_clk)
      if (rvld === 1'b1)
         chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   task automatic end_of_test();
      if (exp_q.size() != 0)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t reads left unanswered", $time);
      end
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      #200us;
      n_fail++;
      $display("CHECK FAILED t=%0t watchdog", $time);
      end_of_test();
   end
   initial
   begin
      logic [7:0] d;
      logic [7:0] cnt [4];
      logic [7:0] za [7];
      cnt = '{default: 8'h00};
      za = '{8'hbb, 8'hbc, 8'hbd, 8'hc0, 8'hc1, 8'hc2, 8'hbe};
      repeat (3) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(8'hb3 + i[7:0], 8'h80 | (8'h08 >> (i % 4)));
      for (int k = 0; k < 7; k++)
         rd(za[k], 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++)
      begin
         d = rnd();
         d[7] = (i < 4);
         wr(8'hb3 + i[7:0], d);
         rd(8'hb3 + i[7:0], {d[7], 7'h08 >> (i % 4)});
      end
      wr(8'hbe, 8'hff);
      rd(8'hbe, 8'h00);
      $display("test split registers done");
      repeat (4)
      begin
         d = rnd();
         wr(8'hc0, d);
         wr(8'hc1, d);
         wr(8'hc2, d);
         rd(8'hc0, d & 8'hc0);
         rd(8'hc1, d & 8'h40);
         rd(8'hc2, d & 8'h3f);
         chk({6'h00, fib}, {6'h00, d[7:6]});
         chk({7'h00, ldo}, {7'h00, d[6]});
         chk({2'h0, vid}, {2'h0, d[5:0]});
      end
      $display("test control bits done");
      wr(8'hbb, 8'h82);
      wr(8'hbc, 8'hff);
      lnk(2, 8'h82);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h00);
      wr(8'hbb, 8'h00);
      cyc(3);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h01);
      wr(8'hbb, 8'h87);
      wr(8'hbc, 8'h02);
      cyc(3);
      rd(8'hbc, 8'h80);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h00);
      wr(8'hbc, 8'h80);
      cyc(3);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h01);
      lnk(1, 8'h81);
      wr(8'hbc, 8'hff);
      lnk(3, 8'h04);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h00);
      wr(8'hbc, 8'h04);
      cyc(3);
      @(negedge i_sys_clk);
      chk({7'h00, irq_n}, 8'h01);
      $display("test link interrupt done");
      @(posedge i_sys_clk);
      ne2 <= 4'hf;
      repeat (15)
      begin
         cyc(3);
         @(negedge i_sys_clk);
         if (gv2 === 1'b1)
            cnt[g2] = cnt[g2] + 8'h01;
         @(posedge i_sys_clk);
         tk2 <= 1'b1;
         @(posedge i_sys_clk);
         tk2 <= 1'b0;
      end
      for (int q = 0; q < 4; q++)
         chk(cnt[q], 8'h01 << q);
      cnt = '{default: 8'h00};
      @(posedge i_sys_clk);
      ne2 <= 4'h3;
      repeat (3)
      begin
         cyc(3);
         @(negedge i_sys_clk);
         if (gv2 === 1'b1)
            cnt[g2] = cnt[g2] + 8'h01;
         @(posedge i_sys_clk);
         tk2 <= 1'b1;
         @(posedge i_sys_clk);
         tk2 <= 1'b0;
      end
      chk(cnt[1], 8'h02);
      chk(cnt[0], 8'h01);
      chk(cnt[3] | cnt[2], 8'h00);
      repeat (4)
      begin
         d = rnd() | 8'h01;
         @(posedge i_sys_clk);
         ne3 <= d[3:0];
         tk3 <= 1'b1;
         @(posedge i_sys_clk);
         tk3 <= 1'b0;
         cyc(4);
         @(negedge i_sys_clk);
         chk({5'h00, gv3, g3}, d[3] ? 8'h07 : d[2] ? 8'h06 : d[1] ? 8'h05 : 8'h04);
      end
      $display("test scheduling done");
      wr(8'hbd, 8'h01);
      pause <= 1'b1;
      cyc(10);
      @(negedge i_sys_clk);
      chk({7'h00, finv}, 8'h00);
      cyc(20);
      @(negedge i_sys_clk);
      chk({7'h00, finv}, 8'h01);
      wr(8'hbd, 8'h00);
      cyc(40);
      @(negedge i_sys_clk);
      chk({7'h00, finv}, 8'h00);
      @(posedge i_sys_clk);
      pause <= 1'b0;
      $display("test pause limit done");
      cyc(4);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
